// ### presence_pkg.sv
// Purpose: Shared constants and types for the presence detection block.
// Assumes: One 25 MHz clock; registers reached over APB.
// Notes: Offsets are byte addresses.
package presence_pkg;

   // Register byte offsets.
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] DELAY_ADDR  = 8'h04;
   localparam logic [7:0] CYCLE_ADDR  = 8'h08;
   localparam logic [7:0] VALUE_ADDR  = 8'h0C;
   localparam logic [7:0] CMD_ADDR    = 8'h10;
   localparam logic [7:0] STATUS_ADDR = 8'h14;
   localparam logic [7:0] TEL_ADDR    = 8'h18;

   // Control field positions.
   localparam int CTRL_START_LSB = 0;
   localparam int CTRL_COMB_BIT  = 2;
   localparam int CTRL_BDEP_BIT  = 3;
   localparam int CTRL_FUNC_LSB  = 4;
   localparam int CTRL_DTEL_BIT  = 7;
   localparam int CTRL_DON_BIT   = 8;

   // Command bits.
   localparam int CMD_LOAD_BIT   = 0;
   localparam int CMD_UNDIS_BIT  = 1;

   // Reset values.
   localparam logic [15:0] DELAY_RST = 16'h0000;
   localparam logic [15:0] CYCLE_RST = 16'h0000;
   localparam logic [15:0] VALUE_RST = 16'h0000;

   // Timer base: one tick per millisecond.
   localparam int unsigned CLK_NS      = 40;
   localparam int unsigned TICK_NS     = 1000000;
   localparam int unsigned TICK_CYC_DF = TICK_NS / CLK_NS;

   // Floating value limits for the temperature format.
   localparam logic [15:0] MANT_MAX  = 16'h07FF;
   localparam logic [15:0] HUNDRED   = 16'h0064;

   // Priority control codes: control bit then value bit.
   localparam logic [1:0] PRIO_ON  = 2'h3;
   localparam logic [1:0] PRIO_OFF = 2'h2;

   // Scene number field mask.
   localparam logic [7:0] SCENE_MASK = 8'h3F;

   typedef enum logic [1:0] {
      START_NONE   = 2'h0,
      START_DIS    = 2'h1,
      START_DETECT = 2'h2
   } startup_e;

   typedef enum logic [2:0] {
      FN_NONE   = 3'h0,
      FN_SWITCH = 3'h1,
      FN_STAIR  = 3'h2,
      FN_FORCE  = 3'h3,
      FN_DIM    = 3'h4,
      FN_SCENE  = 3'h5,
      FN_TEMP   = 3'h6
   } func_e;

   typedef enum logic [1:0] {
      SZ_BIT1  = 2'h0,
      SZ_BIT2  = 2'h1,
      SZ_BYTE1 = 2'h2,
      SZ_BYTE2 = 2'h3
   } size_e;

   typedef enum logic [2:0] {
      ST_BASIC  = 3'b001,
      ST_DETECT = 3'b010,
      ST_DIS    = 3'b100
   } state_e;

   typedef struct packed {
      size_e       size;
      logic [15:0] data;
   } tel_s;

endpackage

// ### tel_encoder.sv
// Purpose: Encodes one output telegram from the selected output function.
// Assumes: Pure combinational; the caller registers the result.
// Notes: Temperature values are whole degrees.
`timescale 1ns/10ps
`default_nettype none
module tel_encoder
   import presence_pkg::*;
(
   input  wire func_e      func,    // Output function.
   input  wire logic       on,      // On telegram when high.
   input  wire logic [7:0] on_val,  // Value at start.
   input  wire logic [7:0] off_val, // Value at end.
   output tel_s            tel,     // Encoded telegram.
   output logic            has_obj  // Output object exists.
);

   // Picks the value, then shapes it to the function's format.
   always_comb
   begin
      logic [7:0]  val;
      logic [15:0] mant;
      logic [3:0]  expo;
      val  = on ? on_val : off_val;
      mant = 16'(val) * HUNDRED;
      expo = 4'h0;
      for (int i = 0; i < 4; i++)
      begin
         if (mant > MANT_MAX)
         begin
            mant = mant >> 1;
            expo = expo + 4'h1;
         end
      end
      has_obj  = (func != FN_NONE);
      tel.size = SZ_BIT1;
      tel.data = 16'h0000;
      unique case (func)
         FN_NONE:   tel.data = 16'h0000;
         FN_SWITCH, FN_STAIR:
            tel.data = {15'h0000, on};
         FN_FORCE:
         begin
            tel.size = SZ_BIT2;
            tel.data = {14'h0000, on ? PRIO_ON : PRIO_OFF};
         end
         FN_DIM:
         begin
            tel.size = SZ_BYTE1;
            tel.data = {8'h00, val};
         end
         FN_SCENE:
         begin
            tel.size = SZ_BYTE1;
            tel.data = {8'h00, (val - 8'h01) & SCENE_MASK};
         end
         FN_TEMP:
         begin
            tel.size = SZ_BYTE2;
            tel.data = {1'b0, expo, mant[10:0]};
         end
         default:   tel.data = 16'h0000;
      endcase
   end

endmodule
`default_nettype wire

// ### presence_block.sv
// Purpose: One motion detection function block with startup behaviour and output one.
// Assumes: Sensor pulses and twilight level arrive synchronous to pclk.
// Notes: Telegrams leave through a valid and ready handshake.
`timescale 1ns/10ps
`default_nettype none
module presence_block
   import presence_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC_DF,
   parameter bit          FIRST_BLOCK = 1'b1
)
(
   input  wire logic        pclk,          // System clock.
   input  wire logic        presetn,       // Asynchronous reset, active low.
   input  wire logic        psel,          // APB select.
   input  wire logic        penable,       // APB enable.
   input  wire logic        pwrite,        // APB direction.
   input  wire logic [7:0]  paddr,         // APB byte address.
   input  wire logic [31:0] pwdata,        // APB write data.
   output logic [31:0]      prdata,        // APB read data.
   output logic             pready,        // APB ready.
   output logic             pslverr,       // APB error.
   input  wire logic        motion_pulse,  // One pulse per detected motion.
   input  wire logic        below_twilight,// Brightness below twilight level.
   input  wire logic        block_active,  // Block not switched off.
   output logic             tel_valid,     // Telegram pending.
   input  wire logic        tel_ready,     // Bus side takes telegram.
   output tel_s             tel,           // Telegram content.
   output logic             presence_lc,   // Presence to light control.
   output logic             disable_lc     // Disable to light control.
);

   // Configuration.
   startup_e    startup;
   logic        comb_cfg;
   logic        bright_dep;
   func_e       out_func;
   logic        dis_tel_en;
   logic        dis_on;
   logic [15:0] delay_ticks;
   logic [15:0] cycle_ticks;
   logic [7:0]  on_val;
   logic [7:0]  off_val;

   // Block state.
   state_e      state;
   state_e      prev_state;
   logic        delay_run;
   logic [15:0] delay_cnt;
   logic [15:0] cycle_cnt;
   logic        indep;
   logic [31:0] tick_cnt;
   logic        tick;

   // Bus decode.
   logic        setup_ph;
   logic        wr_acc;
   logic        addr_ok;
   logic        load_cmd;
   logic        undis_cmd;
   logic        combined;

   // Events.
   logic        ev_start;
   logic        ev_end;
   logic        ev_dis;
   logic        ev_cycle;
   logic        motion_ok;
   logic        delay_done;
   logic        send_req;
   logic        send_on;
   tel_s        enc_tel;
   logic        has_obj;

   // Zero wait states; the read word is captured in the setup phase.
   assign pready   = 1'b1;
   assign setup_ph = psel & ~penable;
   assign wr_acc   = psel & penable & pwrite & ~pslverr;

   // Known offsets only.
   always_comb
   begin
      unique case (paddr)
         CTRL_ADDR, DELAY_ADDR, CYCLE_ADDR, VALUE_ADDR,
         CMD_ADDR, STATUS_ADDR, TEL_ADDR: addr_ok = 1'b1;
         default:                         addr_ok = 1'b0;
      endcase
   end

   // Combined operation exists only on the first block.
   assign combined = comb_cfg & FIRST_BLOCK;

   // Command strobes; inactive blocks ignore the download.
   assign load_cmd  = wr_acc & (paddr == CMD_ADDR) & pwdata[CMD_LOAD_BIT]
                      & block_active;
   assign undis_cmd = wr_acc & (paddr == CMD_ADDR) & pwdata[CMD_UNDIS_BIT];

   // Error answer is fixed in the setup phase.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pslverr <= 1'b0;
      else if (setup_ph)
         pslverr <= ~addr_ok;
   end

   // Read data register.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (setup_ph)
      begin
         unique case (paddr)
            CTRL_ADDR:   prdata <= {23'h00_0000, dis_on, dis_tel_en, out_func,
                                    bright_dep, comb_cfg, startup};
            DELAY_ADDR:  prdata <= {16'h0000, delay_ticks};
            CYCLE_ADDR:  prdata <= {16'h0000, cycle_ticks};
            VALUE_ADDR:  prdata <= {16'h0000, off_val, on_val};
            STATUS_ADDR: prdata <= {22'h00_0000, has_obj, tel_valid, disable_lc,
                                    presence_lc, indep, delay_run, state, combined};
            TEL_ADDR:    prdata <= {14'h0000, tel};
            default:     prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Configuration registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         startup     <= START_NONE;
         comb_cfg    <= 1'b0;
         bright_dep  <= 1'b0;
         out_func    <= FN_NONE;
         dis_tel_en  <= 1'b0;
         dis_on      <= 1'b0;
         delay_ticks <= DELAY_RST;
         cycle_ticks <= CYCLE_RST;
         on_val      <= VALUE_RST[7:0];
         off_val     <= VALUE_RST[15:8];
      end
      else if (wr_acc)
      begin
         unique case (paddr)
            CTRL_ADDR:
            begin
               startup    <= startup_e'(pwdata[CTRL_START_LSB +: 2]);
               comb_cfg   <= pwdata[CTRL_COMB_BIT];
               bright_dep <= pwdata[CTRL_BDEP_BIT];
               out_func   <= func_e'(pwdata[CTRL_FUNC_LSB +: 3]);
               dis_tel_en <= pwdata[CTRL_DTEL_BIT];
               dis_on     <= pwdata[CTRL_DON_BIT];
            end
            DELAY_ADDR: delay_ticks <= pwdata[15:0];
            CYCLE_ADDR: cycle_ticks <= pwdata[15:0];
            VALUE_ADDR:
            begin
               on_val  <= pwdata[7:0];
               off_val <= pwdata[15:8];
            end
            default: ;
         endcase
      end
   end

   // Millisecond tick enable.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tick_cnt <= 32'h0000_0000;
      else if (tick_cnt >= 32'(TICK_CYCLES - 1))
         tick_cnt <= 32'h0000_0000;
      else
         tick_cnt <= tick_cnt + 32'h0000_0001;
   end
   assign tick = (tick_cnt >= 32'(TICK_CYCLES - 1));

   // Motion counts during detection only when not gated by brightness.
   assign motion_ok  = motion_pulse & (~bright_dep | indep | below_twilight);
   assign delay_done = delay_run & tick & (delay_cnt <= 16'h0001);

   // Detection events.
   assign ev_start = (load_cmd & (startup == START_DETECT))
                     | ((state == ST_BASIC) & motion_ok & ~load_cmd
                        & block_active);
   assign ev_end   = (state == ST_DETECT) & delay_done & ~motion_ok
                     & ~load_cmd;
   assign ev_dis   = load_cmd & (startup == START_DIS);
   assign ev_cycle = (state == ST_DETECT) & (out_func == FN_STAIR) & tick
                     & (cycle_cnt <= 16'h0001) & (cycle_ticks != 16'h0000);

   // Main state.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= ST_BASIC;
      else if (load_cmd)
      begin
         unique case (startup)
            START_NONE:   state <= ST_BASIC;
            START_DIS:    state <= ST_DIS;
            START_DETECT: state <= ST_DETECT;
            default:      state <= ST_BASIC;
         endcase
      end
      else
      begin
         unique case (state)
            ST_BASIC:  if (ev_start) state <= ST_DETECT;
            ST_DETECT: if (ev_end) state <= ST_BASIC;
            ST_DIS:    if (undis_cmd) state <= prev_state;
            default:   state <= ST_BASIC;
         endcase
      end
   end

   // State kept for the end of disabling.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prev_state <= ST_BASIC;
      else if (ev_dis)
         prev_state <= ST_BASIC;
   end

   // Transmission delay; each new motion reloads it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         delay_run <= 1'b0;
         delay_cnt <= 16'h0000;
      end
      else if (ev_start | (load_cmd & (startup == START_DETECT)))
      begin
         delay_run <= 1'b1;
         delay_cnt <= delay_ticks;
      end
      else if (load_cmd | ev_end | (state != ST_DETECT))
      begin
         delay_run <= 1'b0;
         delay_cnt <= 16'h0000;
      end
      else if (motion_ok)
         delay_cnt <= delay_ticks;
      else if (delay_run & tick & (delay_cnt != 16'h0000))
         delay_cnt <= delay_cnt - 16'h0001;
   end

   // Switch over to brightness independent detection below twilight.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         indep <= 1'b0;
      else if (load_cmd | ev_end)
         indep <= 1'b0;
      else if ((state == ST_DETECT) & below_twilight)
         indep <= 1'b1;
   end

   // Staircase repeat timer.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cycle_cnt <= 16'h0000;
      else if (ev_start | ev_cycle)
         cycle_cnt <= cycle_ticks;
      else if (tick & (cycle_cnt != 16'h0000))
         cycle_cnt <= cycle_cnt - 16'h0001;
   end

   // Light control indications, first block in combined mode only.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         presence_lc <= 1'b0;
         disable_lc  <= 1'b0;
      end
      else if (!combined)
      begin
         presence_lc <= 1'b0;
         disable_lc  <= 1'b0;
      end
      else if (load_cmd)
      begin
         presence_lc <= (startup == START_DETECT);
         disable_lc  <= (startup == START_DIS);
      end
      else
      begin
         presence_lc <= (state == ST_DETECT) & ~ev_end;
         disable_lc  <= (state == ST_DIS) & ~undis_cmd;
      end
   end

   // Which telegram to send; the light control speaks in combined mode.
   assign send_req = ~combined & has_obj
                     & (ev_start | ev_end | ev_cycle
                        | (ev_dis & dis_tel_en));
   assign send_on  = ev_dis ? dis_on : ~ev_end;

   tel_encoder u_enc
   (
      .func    (out_func),
      .on      (send_on),
      .on_val  (on_val),
      .off_val (off_val),
      .tel     (enc_tel),
      .has_obj (has_obj)
   );

   // Telegram register; a request while one is pending replaces it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tel_valid <= 1'b0;
         tel       <= '0;
      end
      else if (send_req)
      begin
         tel_valid <= 1'b1;
         tel       <= enc_tel;
      end
      else if (tel_ready)
         tel_valid <= 1'b0;
   end

endmodule
`default_nettype wire

// ### presence_block_chk.sv
// Purpose: Port assertions for the presence block.
// Assumes: APB and telegram timing as handed over by the designer.
// Notes: Mirrors control writes to know the mode in force.
`timescale 1ns/10ps
`default_nettype none
module presence_block_chk
   import presence_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = 4,
   parameter bit          FIRST_BLOCK = 1'b1
)
(
   input wire logic        pclk,         // Clock.
   input wire logic        presetn,      // Reset, active low.
   input wire logic        psel,         // Select.
   input wire logic        penable,      // Enable.
   input wire logic        pwrite,       // Direction.
   input wire logic [7:0]  paddr,        // Address.
   input wire logic [31:0] pwdata,       // Write data.
   input wire logic        block_active, // Block enabled.
   input wire logic        tel_valid,    // Telegram pending.
   input wire logic        tel_ready,    // Telegram taken.
   input wire tel_s        tel,          // Telegram.
   input wire logic        presence_lc,  // Presence out.
   input wire logic        disable_lc    // Disable out.
);
   logic       comb_q;  // Combined mode in force.
   logic [1:0] start_q; // Startup setting in force.
   logic [2:0] func_q;  // Output function in force.
   logic       load_w;  // Download command written.

   // A download is a write of the load bit to the command word.
   assign load_w = psel && penable && pwrite && paddr == CMD_ADDR && pwdata[CMD_LOAD_BIT];

   // Mirror the control fields that decide whether telegrams may leave.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         comb_q  <= 1'b0;
         start_q <= 2'h0;
         func_q  <= 3'h0;
      end
      else if (psel && penable && pwrite && paddr == CTRL_ADDR)
      begin
         comb_q  <= pwdata[CTRL_COMB_BIT] && FIRST_BLOCK;
         start_q <= pwdata[CTRL_START_LSB +: 2];
         func_q  <= pwdata[CTRL_FUNC_LSB +: 3];
      end

   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   tel_hold_a: assert property (tel_valid && !tel_ready |=> tel_valid)
      else $error("pending telegram dropped");
   bit_format_a: assert property (tel_valid && tel.size == SZ_BIT1 |-> tel.data[15:1] == 0)
      else $error("one-bit telegram carries more bits");
   prio_format_a: assert property (tel_valid && tel.size == SZ_BIT2 |-> tel.data[15:1] == 1)
      else $error("priority telegram lacks its control bit");
   comb_quiet_a: assert property (comb_q |-> !$rose(tel_valid))
      else $error("telegram sent in combined mode");
   none_quiet_a: assert property (func_q == FN_NONE |-> !$rose(tel_valid))
      else $error("telegram sent without an output object");
   skip_idle_a: assert property (load_w && !block_active |=>
      (!$rose(tel_valid) && $stable(presence_lc) && $stable(disable_lc))[*2])
      else $error("inactive block reacted to download");
   lc_detect_a: assert property (load_w && block_active && comb_q && start_q == START_DETECT
      |-> ##[1:2] presence_lc && !disable_lc)
      else $error("presence not raised on forced detection");
   lc_disable_a: assert property (load_w && block_active && comb_q && start_q == START_DIS
      |-> ##[1:2] disable_lc && !presence_lc)
      else $error("disable not passed on forced disabling");

   cover property ($rose(tel_valid));
   cover property ($rose(presence_lc));
   cover property ($rose(disable_lc));
endmodule
`default_nettype wire

// ### tel_sink.sv
// Purpose: Bus side model that takes telegrams from the block.
// Assumes: Valid and ready handshake, taken when both are high.
// Notes: Stalls zero to three cycles at random before taking.
`timescale 1ns/10ps
`default_nettype none
module tel_sink
(
   input  wire logic pclk,      // Clock.
   input  wire logic presetn,   // Reset, active low.
   input  wire logic tel_valid, // Telegram pending.
   output var  logic tel_ready  // Telegram taken.
);
   integer     seed = 32'h3566_6ba2;
   logic [1:0] wait_cnt;

   // Count down a random stall, then take the pending telegram.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         wait_cnt  <= 2'h0;
         tel_ready <= 1'b0;
      end
      else if (tel_valid && !tel_ready && wait_cnt == 2'h0)
         tel_ready <= 1'b1;
      else if (tel_valid && !tel_ready)
         wait_cnt <= wait_cnt - 2'h1;
      else
      begin
         tel_ready <= 1'b0;
         wait_cnt  <= 2'($random(seed));
      end
endmodule
`default_nettype wire

// ### test_presence_block.sv
// Purpose: Self-checking bench for the presence block.
// Assumes: Short timer tick; the sink model takes telegrams.
// Notes: Telegrams are queued as taken and compared in order.
`timescale 1ns/10ps
`default_nettype none
module test_presence_block
   import presence_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic        motion_pulse, below_twilight, block_active;
   logic        tel_valid, tel_ready, presence_lc, disable_lc;
   logic [7:0]  paddr, v0, v1;
   logic [31:0] pwdata, prdata, r;
   tel_s        tel, t, got[$];
   func_e       fsel;
   integer      seed, fails, comparisons;

   presence_block #(.TICK_CYCLES(8), .FIRST_BLOCK(1'b1)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .motion_pulse(motion_pulse), .below_twilight(below_twilight),
      .block_active(block_active), .tel_valid(tel_valid), .tel_ready(tel_ready),
      .tel(tel), .presence_lc(presence_lc), .disable_lc(disable_lc));
   tel_sink sink (.pclk(pclk), .presetn(presetn), .tel_valid(tel_valid), .tel_ready(tel_ready));

   // Free-running 25 MHz clock.
   always #20 pclk = ~pclk;

   // Queue each telegram at the edge where the sink takes it.
   always @(posedge pclk)
      if (tel_valid === 1'b1 && tel_ready === 1'b1)
         got.push_back(tel);

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      comparisons++;
      if (g !== x)
      begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
   endtask

   // One APB transfer; read data and error land in r and e.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic load();
      apb(1'b1, CMD_ADDR, 32'h0000_0001);
   endtask

   // Waits a bounded time for the next taken telegram.
   task automatic pop();
      int n;
      n = 0;
      while (got.size() == 0 && n < 400)
      begin
         @(posedge pclk);
         n++;
      end
      fails += (got.size() == 0);
      t = (got.size() > 0) ? got.pop_front() : '1;
   endtask

   function automatic logic [31:0] ctrl(input startup_e s, input func_e f, input logic [31:0] x);
      return 32'(s) | (32'(f) << CTRL_FUNC_LSB) | x;
   endfunction

   // Expected telegram for a function, on or off, and a configured value.
   function automatic tel_s exp_tel(input func_e f, input logic on, input logic [7:0] v);
      logic [15:0] m;
      logic [3:0]  x;
      m = 16'(v) * HUNDRED;
      x = 4'h0;
      while (m > MANT_MAX)
      begin
         m = m >> 1;
         x++;
      end
      case (f)
         FN_FORCE: return '{SZ_BIT2, on ? 16'(PRIO_ON) : 16'(PRIO_OFF)};
         FN_DIM:   return '{SZ_BYTE1, 16'(v)};
         FN_SCENE: return '{SZ_BYTE1, 16'((v - 8'h01) & SCENE_MASK)};
         FN_TEMP:  return '{SZ_BYTE2, {1'b0, x, m[10:0]}};
         default:  return '{SZ_BIT1, 16'(on)};
      endcase
   endfunction

   // Legal random value per function, or the dim, scene or temperature upper bound when hi is set.
   function automatic logic [7:0] pick(input func_e f, input int hi);
      case (f)
         FN_DIM:   return hi ? 8'h64 : 8'({$random(seed)} % 101);
         FN_SCENE: return hi ? 8'h40 : 8'(1 + {$random(seed)} % 64);
         FN_TEMP:  return hi ? 8'h28 : 8'({$random(seed)} % 41);
         default:  return 8'($random(seed));
      endcase
   endfunction

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Main sequence.
   initial
   begin
      seed = 32'h3566_6ba2;
      fails = 0;
      comparisons = 0;
      {pclk, presetn, psel, penable, pwrite, motion_pulse, below_twilight} = 7'h00;
      {paddr, pwdata} = 40'h00_0000_0000;
      block_active = 1'b1;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, STATUS_ADDR, 32'h0000_0000);
      chk(r, 32'h0000_0002);
      apb(1'b0, 8'h1C, 32'h0000_0000);
      chk({e, r[30:0]}, 32'h8000_0000);
      apb(1'b1, DELAY_ADDR, 32'h0000_0008);
      apb(1'b1, CYCLE_ADDR, 32'h0000_0003);
      $display("test reset finished");
      // Forced detection for every output function, random then extreme values.
      for (int p = 0; p < 2; p++)
         for (int f = 0; f < 7; f++)
         begin
            fsel = func_e'(f);
            v0 = pick(fsel, p);
            v1 = pick(fsel, 0);
            apb(1'b1, VALUE_ADDR, {16'h0000, v1, v0});
            apb(1'b1, CTRL_ADDR, ctrl(START_DETECT, fsel, 32'h0000_0000));
            load();
            if (fsel == FN_NONE)
            begin
               idle(100);
               chk(got.size(), 0);
               continue;
            end
            pop();
            chk(t, exp_tel(fsel, 1'b1, v0));
            apb(1'b0, STATUS_ADDR, 32'h0000_0000);
            chk({r[9], r[4:1]}, 5'h1A);
            if (fsel == FN_STAIR)
            begin
               pop();
               chk(t, exp_tel(fsel, 1'b1, v0));
            end
            do
               pop();
            while (fsel == FN_STAIR && t === exp_tel(fsel, 1'b1, v0));
            chk(t, exp_tel(fsel, 1'b0, v1));
         end
      $display("test functions finished");
      // Motion during the delay keeps restarting it.
      apb(1'b1, CTRL_ADDR, ctrl(START_DETECT, FN_SWITCH, 32'h0000_0000));
      load();
      pop();
      repeat (5)
      begin
         idle(20 + {$random(seed)} % 20);
         motion_pulse <= 1'b1;
         @(posedge pclk);
         motion_pulse <= 1'b0;
      end
      chk(got.size(), 0);
      pop();
      chk(t, exp_tel(FN_SWITCH, 1'b0, 8'h00));
      $display("test retrigger finished");
      // Forced disabling sends its telegram; ending it restores the basic state.
      for (int d = 0; d < 2; d++)
      begin
         fsel = d ? FN_SWITCH : FN_FORCE;
         apb(1'b1, CTRL_ADDR, ctrl(START_DIS, fsel, 32'h0000_0080 | (d << CTRL_DON_BIT)));
         load();
         pop();
         chk(t, exp_tel(fsel, d[0], 8'h00));
         apb(1'b0, STATUS_ADDR, 32'h0000_0000);
         chk(r[3:1], 3'h4);
         apb(1'b1, CMD_ADDR, 32'h0000_0002);
         apb(1'b0, STATUS_ADDR, 32'h0000_0000);
         chk(r[4:1], 4'h1);
      end
      idle(30);
      got.delete();
      $display("test disabling finished");
      // Combined mode drives the light control and sends nothing itself.
      apb(1'b1, CTRL_ADDR, ctrl(START_DETECT, FN_SWITCH, 32'h0000_0004));
      load();
      apb(1'b0, STATUS_ADDR, 32'h0000_0000);
      chk({disable_lc, presence_lc, r[4:0]}, 7'h35);
      apb(1'b1, CTRL_ADDR, ctrl(START_DIS, FN_SWITCH, 32'h0000_0084));
      load();
      idle(2);
      chk({disable_lc, presence_lc}, 2'h2);
      apb(1'b1, CTRL_ADDR, ctrl(START_NONE, FN_SWITCH, 32'h0000_0004));
      load();
      idle(2);
      chk({disable_lc, presence_lc}, 2'h0);
      idle(80);
      chk(got.size(), 0);
      // No reaction in autonomous mode stops detection without a telegram.
      apb(1'b1, CTRL_ADDR, ctrl(START_DETECT, FN_SWITCH, 32'h0000_0000));
      load();
      pop();
      apb(1'b1, CTRL_ADDR, ctrl(START_NONE, FN_SWITCH, 32'h0000_0000));
      load();
      apb(1'b0, STATUS_ADDR, 32'h0000_0000);
      chk(r[4:1], 4'h1);
      idle(80);
      chk(got.size(), 0);
      // An inactive block ignores the download.
      block_active <= 1'b0;
      apb(1'b1, CTRL_ADDR, ctrl(START_DETECT, FN_SWITCH, 32'h0000_0000));
      load();
      idle(20);
      apb(1'b0, STATUS_ADDR, 32'h0000_0000);
      chk({got.size(), r[3:1]}, 3'h1);
      block_active <= 1'b1;
      $display("test modes finished");
      // Brightness-dependent start switches over only below twilight.
      for (int b = 0; b < 2; b++)
      begin
         below_twilight <= b[0];
         apb(1'b1, CTRL_ADDR, ctrl(START_DETECT, FN_SWITCH, 32'h0000_0008));
         load();
         pop();
         chk(t, exp_tel(FN_SWITCH, 1'b1, 8'h00));
         apb(1'b0, STATUS_ADDR, 32'h0000_0000);
         chk(r[5], b[0]);
         pop();
      end
      $display("test twilight finished");
      end_sim();
   end

   // Watchdog against a hang.
   initial
   begin
      #(40 * 40000);
      fails++;
      end_sim();
   end
endmodule

bind presence_block presence_block_chk #(.TICK_CYCLES(TICK_CYCLES), .FIRST_BLOCK(FIRST_BLOCK))
   chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .block_active(block_active), .tel_valid(tel_valid),
   .tel_ready(tel_ready), .tel(tel), .presence_lc(presence_lc), .disable_lc(disable_lc));
`default_nettype wire
